// File: ssl_supervisor.sv
// Purpose: Address filter and error policy supervisor for two link ports
// Assumes: Receiver and drive logic share clk
// Notes: Error and response timers count 0.1 s ticks, no-access timer 1 s ticks, of one divider
`timescale 1ns/1ps

// What this block does
// R1 - Two independent ports, each separately configured
// R2 - Address ranges and broadcast per protocol
// R3 - Bad station address: broadcast only, no replies
// R4 - Address, parity, framing, protocol, timeout are errors
// R5 - Errors count only when running under link command
// R6 - Policy 0 trips at once with alarm
// R7 - Policy 1 runs for timer, then trips
// R8 - Policy 2 retries for timer; recovery resumes
// R9 - Policy 3 keeps running on errors
// R10 - Error timer 0.0 to 60.0 s per port
// R11 - Unanswered response request past timer is error
// R12 - No-access time 0 off, 1-60 s timeout
// R13 - Protocol select 0, 1, 2 per port
// R14 - Drop queries matching neither own nor broadcast
// R15 - Alarm holds until alarm reset
module ssl_supervisor
  import ssl_pkg::*;
#(
  parameter int TICK_CYC = SSL_TICK_CYC // Clocks per 0.1 s tick
)(
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [SSL_AW-1:0] addr,
  input wire logic [SSL_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [SSL_DW-1:0] rdata,
  // Drive status
  input wire logic drive_running,
  input wire logic run_from_link [SSL_NPORT],
  input wire logic freq_from_link [SSL_NPORT],
  input wire logic alarm_reset,
  // Receiver side per port
  input wire ssl_query_t query [SSL_NPORT],
  input wire logic resp_request [SSL_NPORT],
  input wire logic resp_received [SSL_NPORT],
  // Results per port, then shared drive stop and irq
  output logic accept [SSL_NPORT],
  output logic reply_en [SSL_NPORT],
  output logic port_alarm [SSL_NPORT],
  output logic drive_stop,
  output logic irq
);

  // ----------------------------------------------------------------
  // Shared tick divider
  // ----------------------------------------------------------------
  logic [31:0] div_cnt; // Clocks into tick
  logic tick; // One-cycle 0.1 s enable
  logic [3:0] tenth_cnt; // Ticks into second
  logic sec_tick; // One-cycle 1 s enable

  // Divide clk to the 0.1 s tick
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt <= '0;
      tick <= 1'b0;
    end
    else if (div_cnt == 32'(TICK_CYC - 1))
    begin
      div_cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Divide tick to the 1 s tick
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tenth_cnt <= '0;
      sec_tick <= 1'b0;
    end
    else if (tick && tenth_cnt == SSL_TICKS_PER_S - 4'h1)
    begin
      tenth_cnt <= '0;
      sec_tick <= 1'b1;
    end
    else
    begin
      if (tick)
        tenth_cnt <= tenth_cnt + 4'h1;
      sec_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per port state
  // ----------------------------------------------------------------
  logic [7:0] std_station [SSL_NPORT]; // Station address setting
  logic [1:0] err_policy [SSL_NPORT]; // Error policy setting
  logic [9:0] err_timer [SSL_NPORT]; // Error timer, tenths
  logic [5:0] noacc_time [SSL_NPORT]; // No-access time, seconds
  logic [1:0] proto_sel [SSL_NPORT]; // Protocol select
  ssl_state_t state [SSL_NPORT]; // Policy state
  logic err_evt [SSL_NPORT]; // Recognised error this cycle
  logic trip_evt [SSL_NPORT]; // Entering trip this cycle
  logic [SSL_IRQ_BITS-1:0] irq_stat; // Sticky events
  logic [SSL_IRQ_BITS-1:0] irq_mask; // Enables onto irq
  logic [SSL_IRQ_BITS-1:0] irq_set; // Events this cycle

  genvar p;
  generate
    for (p = 0; p < SSL_NPORT; p++)
    begin : g_port
      logic [2:0] reg_sel; // Register within this port
      logic port_hit; // Access falls in this port's window
      logic addr_ok; // Setting in range for protocol
      logic has_bcast; // Protocol has a broadcast address
      logic [7:0] bcast; // Broadcast address of protocol
      logic own; // Query for this station
      logic is_bcast; // Query is broadcast
      logic line_err; // Raw error before gating
      logic good; // Clean query for us
      logic [9:0] grace_cnt; // Tenths spent in grace
      logic [9:0] resp_cnt; // Tenths waiting for response
      logic resp_wait; // Response request outstanding
      logic resp_tmo; // Response wait expired
      logic [5:0] noacc_cnt; // Seconds without access
      logic noacc_tmo; // No-access timeout

      assign reg_sel = addr[2:0];
      assign port_hit = addr[4:3] == 2'(p);

      // Range and broadcast per protocol
      always_comb
      begin
        addr_ok = 1'b0;
        has_bcast = 1'b0;
        bcast = SSL_MODBUS_BCAST;
        unique case (proto_sel[p])
          SSL_PROTO_MODBUS:
          begin
            addr_ok = std_station[p] >= SSL_ADDR_MIN && std_station[p] <= SSL_MODBUS_MAX; // R2
            has_bcast = 1'b1; // R2
          end
          SSL_PROTO_LOADER:
            addr_ok = std_station[p] >= SSL_ADDR_MIN && std_station[p] <= SSL_LOADER_MAX; // R2
          SSL_PROTO_VENDOR:
          begin
            addr_ok = std_station[p] >= SSL_ADDR_MIN && std_station[p] <= SSL_VENDOR_MAX; // R2
            has_bcast = 1'b1;
            bcast = SSL_VENDOR_BCAST; // R2
          end
          default:
            addr_ok = 1'b0; // Unknown protocol answers nothing
        endcase
      end

      // Own or broadcast match; others drop
      assign own = addr_ok && query[p].station == std_station[p]; // R3 R14
      assign is_bcast = has_bcast && query[p].station == bcast; // R14
      assign good = query[p].valid && (own || is_bcast) && !query[p].parity_err
        && !query[p].framing_err && !query[p].proto_err && !query[p].addr_err;

      // Error sources of this port
      assign line_err = (query[p].valid && (query[p].parity_err || query[p].framing_err))
        || (query[p].valid && (own || is_bcast) && (query[p].proto_err || query[p].addr_err))
        || noacc_tmo || resp_tmo; // R4 R11 R12
      // Only while running under link command
      assign err_evt[p] = line_err && drive_running
        && (run_from_link[p] || freq_from_link[p]); // R5

      // Accept and reply strobes
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          accept[p] <= 1'b0;
          reply_en[p] <= 1'b0;
        end
        else
        begin
          accept[p] <= good; // R14
          reply_en[p] <= good && own; // R3
        end
      end

      // Configuration registers
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          std_station[p] <= SSL_RST_STATION;
          err_policy[p] <= SSL_POL_TRIP;
          err_timer[p] <= '0;
          noacc_time[p] <= '0;
          proto_sel[p] <= SSL_PROTO_MODBUS;
        end
        else if (wr && port_hit)
        begin
          unique case (reg_sel)
            SSL_REG_STATION: std_station[p] <= wdata[7:0]; // R1
            SSL_REG_POLICY: err_policy[p] <= wdata[1:0];
            SSL_REG_ERR_TMR: // R10
              err_timer[p] <= wdata[9:0] > SSL_ERR_TMR_MAX ? SSL_ERR_TMR_MAX : wdata[9:0];
            SSL_REG_NOACC: // R12
              noacc_time[p] <= wdata[5:0] > SSL_NOACC_MAX ? SSL_NOACC_MAX : wdata[5:0];
            SSL_REG_PROTO: proto_sel[p] <= wdata[1:0]; // R13
            default: ; // Read-only or unmapped
          endcase
        end
      end

      // No-access watchdog in whole seconds
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          noacc_cnt <= '0;
          noacc_tmo <= 1'b0;
        end
        else if (noacc_time[p] == 6'h0 || good)
        begin
          noacc_cnt <= '0; // R12
          noacc_tmo <= 1'b0;
        end
        else if (sec_tick && noacc_cnt + 6'h1 >= noacc_time[p])
        begin
          noacc_cnt <= '0; // Rearm after each report
          noacc_tmo <= 1'b1; // R12
        end
        else
        begin
          if (sec_tick)
            noacc_cnt <= noacc_cnt + 6'h1;
          noacc_tmo <= 1'b0;
        end
      end

      // Response wait timer
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          resp_wait <= 1'b0;
          resp_cnt <= '0;
          resp_tmo <= 1'b0;
        end
        else if (resp_received[p])
        begin
          resp_wait <= 1'b0; // Answer arrived in time
          resp_tmo <= 1'b0;
        end
        else if (resp_request[p])
        begin
          resp_wait <= 1'b1;
          resp_cnt <= '0;
          resp_tmo <= 1'b0;
        end
        else if (resp_wait && (tick || err_timer[p] == 10'h0)
          && resp_cnt + 10'h1 >= err_timer[p])
        begin
          resp_wait <= 1'b0;
          resp_tmo <= 1'b1; // R11
        end
        else
        begin
          if (resp_wait && tick)
            resp_cnt <= resp_cnt + 10'h1;
          resp_tmo <= 1'b0;
        end
      end

      // Error policy state machine
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          state[p] <= SSL_IDLE;
          grace_cnt <= '0;
          trip_evt[p] <= 1'b0;
        end
        else
        begin
          trip_evt[p] <= 1'b0;
          unique case (state[p])
            SSL_IDLE:
              if (err_evt[p])
              begin
                grace_cnt <= '0;
                if (err_policy[p] == SSL_POL_TRIP)
                begin
                  state[p] <= SSL_TRIP; // R6
                  trip_evt[p] <= 1'b1;
                end
                else if (err_policy[p] != SSL_POL_KEEP)
                  state[p] <= SSL_GRACE; // R7 R8
                // Policy 3 stays idle
              end // R9
            SSL_GRACE:
              if (err_policy[p] == SSL_POL_RETRY && good && !err_evt[p])
                state[p] <= SSL_IDLE; // R8
              else if (err_policy[p] == SSL_POL_KEEP)
                state[p] <= SSL_IDLE; // R9
              else if ((tick || err_timer[p] == 10'h0)
                && grace_cnt + 10'h1 >= err_timer[p])
              begin
                state[p] <= SSL_TRIP; // R7 R8
                trip_evt[p] <= 1'b1;
              end
              else if (tick)
                grace_cnt <= grace_cnt + 10'h1;
            SSL_TRIP:
              if (alarm_reset)
                state[p] <= SSL_IDLE; // R15
            default:
              state[p] <= SSL_IDLE; // Illegal code recovers
          endcase
        end
      end

      // Alarm flag per port
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          port_alarm[p] <= 1'b0;
        else if (trip_evt[p])
          port_alarm[p] <= 1'b1; // R6 R7 R8
        else if (alarm_reset)
          port_alarm[p] <= 1'b0; // R15
      end

      assign irq_set[2*p] = err_evt[p];
      assign irq_set[2*p+1] = trip_evt[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Drive stop and interrupts
  // ----------------------------------------------------------------
  logic any_alarm; // Some port holds an alarm

  always_comb
  begin
    any_alarm = 1'b0;
    for (int i = 0; i < SSL_NPORT; i++)
      any_alarm = any_alarm | port_alarm[i];
  end

  // Stop the drive while any alarm stands
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      drive_stop <= 1'b0;
    else
      drive_stop <= any_alarm;
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_stat <= '0;
    else if (wr && addr == SSL_REG_IRQ_STAT)
      irq_stat <= (irq_stat & ~wdata[SSL_IRQ_BITS-1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  // Mask register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_mask <= '0;
    else if (wr && addr == SSL_REG_IRQ_MASK)
      irq_mask <= wdata[SSL_IRQ_BITS-1:0];
  end

  // Level interrupt
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [SSL_DW-1:0] next_rdata; // Data for the next cycle
  logic rp; // Port selected by address

  always_comb
  begin
    next_rdata = '0;
    rp = addr[3];
    if (addr == SSL_REG_IRQ_STAT)
      next_rdata = SSL_DW'(irq_stat);
    else if (addr == SSL_REG_IRQ_MASK)
      next_rdata = SSL_DW'(irq_mask);
    else if (!addr[4])
    begin
      unique case (addr[2:0])
        SSL_REG_STATION: next_rdata = SSL_DW'(std_station[rp]);
        SSL_REG_POLICY: next_rdata = SSL_DW'(err_policy[rp]);
        SSL_REG_ERR_TMR: next_rdata = SSL_DW'(err_timer[rp]);
        SSL_REG_NOACC: next_rdata = SSL_DW'(noacc_time[rp]);
        SSL_REG_PROTO: next_rdata = SSL_DW'(proto_sel[rp]);
        SSL_REG_PSTAT: next_rdata = SSL_DW'({port_alarm[rp], state[rp]});
        default: next_rdata = '0;
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata <= '0;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= '0;
  end

endmodule // ssl_supervisor

// File: ssl_pkg.sv
// Purpose: Shared constants and types for the serial link supervisor
// Assumes: One 20 MHz clock, word-indexed register port
// Notes: Settings are per port; port 0 standard, 1 card
package ssl_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int SSL_NPORT = 2; // Standard and card port
  localparam int SSL_CLK_NS = 50; // Clock period, ns
  localparam int SSL_TICK_NS = 100_000_000; // Timer resolution, 0.1 s
  localparam int SSL_TICK_CYC = SSL_TICK_NS / SSL_CLK_NS;
  localparam logic [3:0] SSL_TICKS_PER_S = 4'hA; // Tenths in a second
  localparam logic [9:0] SSL_ERR_TMR_MAX = 10'h258; // 60.0 s in tenths
  localparam logic [5:0] SSL_NOACC_MAX = 6'h3C; // 60 s

  // ----------------------------------------------------------------
  // Register map (word index)
  // ----------------------------------------------------------------
  localparam int SSL_AW = 5;
  localparam int SSL_DW = 16;
  localparam logic [4:0] SSL_PORT_STRIDE = 5'h08; // Port 1 base
  localparam logic [2:0] SSL_REG_STATION = 3'h0;
  localparam logic [2:0] SSL_REG_POLICY = 3'h1;
  localparam logic [2:0] SSL_REG_ERR_TMR = 3'h2;
  localparam logic [2:0] SSL_REG_NOACC = 3'h3;
  localparam logic [2:0] SSL_REG_PROTO = 3'h4;
  localparam logic [2:0] SSL_REG_PSTAT = 3'h5;
  localparam logic [4:0] SSL_REG_IRQ_STAT = 5'h10;
  localparam logic [4:0] SSL_REG_IRQ_MASK = 5'h11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SSL_RST_STATION = 8'h01;

  // ----------------------------------------------------------------
  // Protocols, addresses, policies
  // ----------------------------------------------------------------
  localparam logic [1:0] SSL_PROTO_MODBUS = 2'h0;
  localparam logic [1:0] SSL_PROTO_LOADER = 2'h1;
  localparam logic [1:0] SSL_PROTO_VENDOR = 2'h2;
  localparam logic [7:0] SSL_ADDR_MIN = 8'h01;
  localparam logic [7:0] SSL_MODBUS_MAX = 8'hF7; // 247
  localparam logic [7:0] SSL_LOADER_MAX = 8'hFF; // 255
  localparam logic [7:0] SSL_VENDOR_MAX = 8'h1F; // 31
  localparam logic [7:0] SSL_MODBUS_BCAST = 8'h00;
  localparam logic [7:0] SSL_VENDOR_BCAST = 8'h63; // 99
  localparam logic [1:0] SSL_POL_TRIP = 2'h0;
  localparam logic [1:0] SSL_POL_RUNON = 2'h1;
  localparam logic [1:0] SSL_POL_RETRY = 2'h2;
  localparam logic [1:0] SSL_POL_KEEP = 2'h3;

  // Interrupt bit layout per port: error seen, trip
  localparam int SSL_IRQ_BITS = 2 * SSL_NPORT;

  // Per port supervisor state, Gray along idle-grace-trip
  typedef enum logic [1:0] {
    SSL_IDLE = 2'b00,
    SSL_GRACE = 2'b01,
    SSL_TRIP = 2'b11
  } ssl_state_t;

  // One received query as reported by the frame receiver
  typedef struct packed {
    logic valid; // One-cycle pulse per finished frame
    logic [7:0] station; // Station field of the frame
    logic parity_err;
    logic framing_err;
    logic proto_err;
    logic addr_err;
  } ssl_query_t;

endpackage

// File: ssl_sup_monitor.sv
// Purpose: Port assertions for the link supervisor
// Assumes: One clock, asynchronous active high reset
// Notes: Bound into every ssl_supervisor instance
`timescale 1ns/1ps
module ssl_sup_monitor
  import ssl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic rd,
  input wire logic [SSL_DW-1:0] rdata,
  input wire logic drive_running,
  input wire logic alarm_reset,
  input wire ssl_query_t query [SSL_NPORT],
  input wire logic accept [SSL_NPORT],
  input wire logic reply_en [SSL_NPORT],
  input wire logic port_alarm [SSL_NPORT],
  input wire logic drive_stop,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_acc_cause;
    !query[0].valid |=> !accept[0];
  endproperty
  a_acc_cause: assert property (p_acc_cause) else $error("accept without query");
  property p_acc_cause1;
    !query[1].valid |=> !accept[1];
  endproperty
  a_acc_cause1: assert property (p_acc_cause1) else $error("card port accept");
  property p_reply;
    reply_en[0] |-> accept[0];
  endproperty
  a_reply: assert property (p_reply) else $error("reply without accept");
  property p_err_drop;
    query[0].valid && (query[0].parity_err || query[0].framing_err) |=> !accept[0];
  endproperty
  a_err_drop: assert property (p_err_drop) else $error("bad frame accepted");
  property p_stop;
    $rose(port_alarm[0]) |=> drive_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("alarm without stop");
  property p_idle_stop;
    !port_alarm[0] && !port_alarm[1] |=> !drive_stop;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("stop without alarm");
  property p_hold0;
    port_alarm[0] && !alarm_reset |=> port_alarm[0];
  endproperty
  a_hold0: assert property (p_hold0) else $error("alarm dropped");
  property p_hold1;
    port_alarm[1] && !alarm_reset |=> port_alarm[1];
  endproperty
  a_hold1: assert property (p_hold1) else $error("card alarm dropped");
  property p_clear;
    alarm_reset && !drive_running |-> ##[1:2] !port_alarm[0];
  endproperty
  a_clear: assert property (p_clear) else $error("alarm not cleared");
  property p_stop_fall;
    $fell(drive_stop) |-> $past(alarm_reset) || $past(alarm_reset, 2) || $past(alarm_reset, 3);
  endproperty
  a_stop_fall: assert property (p_stop_fall) else $error("stop released");
  property p_rdata;
    !rd |=> rdata == '0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("rdata outside slot");
  // Main scenarios reached
  c_accept: cover property (accept[0] && reply_en[0]);
  c_trip: cover property ($rose(port_alarm[0]));
  c_irq: cover property ($rose(irq));
endmodule // ssl_sup_monitor

bind ssl_supervisor ssl_sup_monitor u_mon (.clk(clk), .reset(reset),
  .rd(rd), .rdata(rdata), .drive_running(drive_running), .alarm_reset(alarm_reset),
  .query(query), .accept(accept), .reply_en(reply_en), .port_alarm(port_alarm),
  .drive_stop(drive_stop), .irq(irq));

// File: ssl_host_model.sv
// Purpose: Host side of the link, seen at the frame receiver
// Assumes: Driven from the bench through its tasks
// Notes: Idle station field is scrambled so stale values never match
`timescale 1ns/1ps
module ssl_host_model
  import ssl_pkg::*;
(
  input wire logic clk,
  output ssl_query_t query [SSL_NPORT],
  output logic resp_request [SSL_NPORT],
  output logic resp_received [SSL_NPORT]
);
  initial
  begin
    query = '{default: '0};
    resp_request = '{default: 1'h0};
    resp_received = '{default: 1'h0};
  end
  // One finished frame, err is {parity, framing, protocol, address}
  task automatic send(input int p, input logic [7:0] st, input logic [3:0] err);
    @(posedge clk);
    query[p] <= {1'h1, st, err};
    @(posedge clk);
    query[p] <= {1'h0, ~st, 4'h0};
  endtask
  // Response request, answered two cycles later or never
  task automatic request(input int p, input logic ans);
    @(posedge clk);
    resp_request[p] <= 1'h1;
    @(posedge clk);
    resp_request[p] <= 1'h0;
    if (ans)
    begin
      @(posedge clk);
      resp_received[p] <= 1'h1;
      @(posedge clk);
      resp_received[p] <= 1'h0;
    end
  endtask
endmodule // ssl_host_model

// File: ssl_supervisor_tb_top.sv
// Purpose: Self-checking bench for the link supervisor
// Assumes: TICK_CYC of 4, so one second is 40 clocks
// Notes: Tasks queue expectations for the watcher
`timescale 1ns/1ps
module ssl_supervisor_tb_top
  import ssl_pkg::*;
;
  logic clk = 0;
  logic reset = 1;
  logic [SSL_AW-1:0] addr = '0;
  logic [SSL_DW-1:0] wdata = '0;
  logic wr = 0;
  logic rd = 0;
  logic [SSL_DW-1:0] rdata;
  logic drive_running = 0;
  logic alarm_reset = 0;
  logic run_from_link [SSL_NPORT] = '{1'h0, 1'h0};
  logic freq_from_link [SSL_NPORT] = '{1'h0, 1'h0};
  ssl_query_t query [SSL_NPORT];
  logic resp_request [SSL_NPORT];
  logic resp_received [SSL_NPORT];
  logic accept [SSL_NPORT];
  logic reply_en [SSL_NPORT];
  logic port_alarm [SSL_NPORT];
  logic drive_stop;
  logic irq;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic rd_d = 0;
  logic [1:0] qv_d = '0;
  logic [2:0] e;
  logic [15:0] q_rd [$];
  logic [2:0] q_acc [$];
  initial forever #25 clk = ~clk;
  ssl_supervisor #(.TICK_CYC(4)) dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .drive_running(drive_running),
    .run_from_link(run_from_link), .freq_from_link(freq_from_link),
    .alarm_reset(alarm_reset), .query(query), .resp_request(resp_request),
    .resp_received(resp_received), .accept(accept), .reply_en(reply_en),
    .port_alarm(port_alarm), .drive_stop(drive_stop), .irq(irq));
  ssl_host_model host (.clk(clk), .query(query), .resp_request(resp_request),
    .resp_received(resp_received));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
    n_checks++;
    if (g !== ex)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watcher: pops the oldest note per result
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rd_d <= rd;
    qv_d <= {query[1].valid, query[0].valid};
    if (rd_d && q_rd.size() > 0)
      chk("rdata", q_rd.pop_front(), rdata);
    if (|qv_d && q_acc.size() > 0)
    begin
      e = q_acc.pop_front();
      chk("accept", e[1:0], {accept[e[2]], reply_en[e[2]]});
    end
    if (cyc == 8000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  function automatic logic [4:0] ra(input int p, input logic [2:0] o);
    return {1'h0, p[0], o};
  endfunction
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] ex);
    q_rd.push_back(ex);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
  endtask
  // Expected {accept, reply} for a clean query
  function automatic logic [1:0] exp_q(input logic [1:0] pr, input logic [7:0] own,
    input logic [7:0] st);
    logic [7:0] mx;
    logic inr;
    logic hb;
    mx = pr == 2'h0 ? 8'hF7 : pr == 2'h1 ? 8'hFF : pr == 2'h2 ? 8'h1F : 8'h00;
    hb = pr == 2'h0 || pr == 2'h2;
    inr = own >= 8'h01 && own <= mx;
    return {(inr && st == own) || (hb && st == (pr == 2'h2 ? 8'h63 : 8'h00)), inr && st == own};
  endfunction
  task automatic q(input int p, input logic [1:0] pr, input logic [7:0] own,
    input logic [7:0] st, input logic [3:0] err);
    q_acc.push_back({p[0], err != 4'h0 ? 2'h0 : exp_q(pr, own, st)});
    host.send(p, st, err);
  endtask
  task automatic clr();
    @(posedge clk);
    drive_running <= 1'h0;
    alarm_reset <= 1'h1;
    @(posedge clk);
    alarm_reset <= 1'h0;
    repeat (3) @(posedge clk);
    drive_running <= 1'h1;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int p;
    logic [7:0] own;
    logic [7:0] sl [5];
    logic [15:0] v;
    void'($urandom(47));
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    for (int i = 0; i < 12; i++)
      rd_reg(ra(i / 6, 3'(i % 6)), i % 6 == 0 ? 16'h1 : 16'h0);
    wr_reg(5'h07, 16'hFFFF);
    rd_reg(5'h07, 16'h0);
    wr_reg(ra(0, 2), 16'h3FF);
    rd_reg(ra(0, 2), 16'h258);
    v = 16'($urandom_range(0, 600));
    wr_reg(ra(0, 2), v);
    rd_reg(ra(0, 2), v);
    wr_reg(ra(1, 3), 16'h3F);
    rd_reg(ra(1, 3), 16'h3C);
    wr_reg(ra(1, 3), 16'h0);
    $display("test registers done");
    for (int pr = 0; pr < 4; pr++)
      for (int k = 0; k < 4; k++)
      begin
        p = k % 2;
        own = k == 0 ? 8'($urandom_range(1, 31)) : k == 3 ? 8'hFF : 8'($urandom_range(1, 255));
        wr_reg(ra(p, 0), {8'h00, own});
        wr_reg(ra(p, 4), pr[15:0]);
        rd_reg(ra(p, 4), pr[15:0]);
        sl = '{own, 8'h00, 8'h63, own + 8'h01, 8'($urandom)};
        foreach (sl[i])
          q(p, pr[1:0], own, sl[i], 4'h0);
        for (int b = 0; b < 4; b++)
          q(p, pr[1:0], own, own, 4'h1 << b);
      end
    $display("test address filter done");
    wr_reg(ra(0, 0), 16'h5);
    wr_reg(ra(0, 4), 16'h0);
    wr_reg(ra(0, 2), 16'hA);
    wr_reg(ra(0, 1), 16'h0);
    q(0, 2'h0, 8'h05, 8'h05, 4'h4);
    drive_running <= 1'h1;
    q(0, 2'h0, 8'h05, 8'h05, 4'h4);
    repeat (4) @(posedge clk);
    rd_reg(ra(0, 5), 16'h0);
    rd_reg(SSL_REG_IRQ_STAT, 16'h0);
    run_from_link[0] <= 1'h1;
    for (int pol = 0; pol < 4; pol++)
    begin
      wr_reg(ra(0, 1), pol[15:0]);
      q(0, 2'h0, 8'h05, 8'h05, 4'h8);
      repeat (3) @(posedge clk);
      rd_reg(ra(0, 5), pol == 0 ? 16'h7 : pol == 3 ? 16'h0 : 16'h1);
      if (pol == 2)
        q(0, 2'h0, 8'h05, 8'h05, 4'h0);
      repeat (60) @(posedge clk);
      rd_reg(ra(0, 5), pol < 2 ? 16'h7 : 16'h0);
      chk("drive_stop", 16'(pol < 2), 16'(drive_stop));
      if (pol == 0)
      begin
        rd_reg(SSL_REG_IRQ_STAT, 16'h3);
        chk("irq", 16'h0, 16'(irq));
        wr_reg(SSL_REG_IRQ_MASK, 16'h3);
        repeat (2) @(posedge clk);
        chk("irq", 16'h1, 16'(irq));
        wr_reg(SSL_REG_IRQ_STAT, 16'h3);
        repeat (2) @(posedge clk);
        rd_reg(SSL_REG_IRQ_STAT, 16'h0);
        chk("irq", 16'h0, 16'(irq));
      end
      clr();
      rd_reg(ra(0, 5), 16'h0);
    end
    $display("test policies done");
    wr_reg(ra(0, 1), 16'h0);
    wr_reg(ra(0, 2), 16'h3);
    host.request(0, 1'h1);
    repeat (30) @(posedge clk);
    rd_reg(ra(0, 5), 16'h0);
    host.request(0, 1'h0);
    repeat (30) @(posedge clk);
    rd_reg(ra(0, 5), 16'h7);
    clr();
    $display("test response timeout done");
    wr_reg(SSL_REG_IRQ_STAT, 16'hF);
    wr_reg(SSL_REG_IRQ_MASK, 16'h8);
    wr_reg(ra(1, 0), 16'h9);
    wr_reg(ra(1, 4), 16'h0);
    wr_reg(ra(1, 1), 16'h0);
    freq_from_link[1] <= 1'h1;
    wr_reg(ra(1, 3), 16'h2);
    q(1, 2'h0, 8'h09, 8'h09, 4'h0);
    repeat (20) @(posedge clk);
    rd_reg(ra(1, 5), 16'h0);
    repeat (140) @(posedge clk);
    rd_reg(ra(1, 5), 16'h7);
    chk("irq", 16'h1, 16'(irq));
    clr();
    rd_reg(ra(1, 5), 16'h0);
    repeat (3) @(posedge clk);
    $display("test no access done");
    report_and_stop();
  end
endmodule // ssl_supervisor_tb_top
